// [rtl/mdfr_core.sv]
/*
  Fault response core of a three-phase driver: FET and buck overcurrent,
  comparator and ADC phase current limits, FET thermal warning.
  Assumes raw comparator inputs are asynchronous and a single pclk.
*/
// Register access over APB and the address map were left to the implementer.
// Overview of operation
// - FET overcurrent needs deglitch time exceeded
// - Two-bit mode: latch, retry, report, off
// - Latched OC: FETs off, fault low, flags
// - Latched OC resumes after clear, condition gone
// - Retry OC: resume after retry time
// - Retry OC: OC, FET flags stay until clear
// - Buck overcurrent: buck Hi-Z, enter reset
// - Comparator limit event after its deglitch
// - Comparator latched: bridge per code, clear
// - Comparator retry: bridge per code, auto clear
// - Comparator report keeps driving; 1xx1 ignores
// - ADC limit event after its deglitch
// - ADC latched: bridge per code, clear
// - ADC retry: bridge per code, auto clear
// - ADC report keeps driving; 1xx1 ignores
// - Warning reported only when enable set
// - Thermal warning takes no protective action
// - Warning held until clear and cool
`timescale 1ns/1ns
`default_nettype none
module mdfr_core #(
  parameter int RETRY_TICK_CYC = mdfr_pkg::RETRY_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  fet_oc_raw,
  input  wire logic        buck_oc_raw,
  input  wire logic        cmp_lim_raw,
  input  wire logic        adc_lim_raw,
  input  wire logic        otw_raw,
  output logic             fault_out_n,
  output logic [1:0]       bridge_state,
  output logic             buck_hiz,
  output logic             reset_req
);
  typedef enum logic [2:0] {
    MDFR_RUN  = 3'b001,
    MDFR_HOLD = 3'b010,
    MDFR_WAIT = 3'b100
  } mdfr_st_t;

  // Two-flop synchronisers for the analog comparator levels
  logic [9:0] sync1_q, sync2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce) begin
      sync1_q <= {otw_raw, adc_lim_raw, cmp_lim_raw, buck_oc_raw, fet_oc_raw};
      sync2_q <= sync1_q;
    end
  end
  logic [5:0] fet_oc_s;
  logic       buck_s, cmp_s, adc_s, otw_s;
  assign fet_oc_s = sync2_q[5:0];
  assign buck_s   = sync2_q[6];
  assign cmp_s    = sync2_q[7];
  assign adc_s    = sync2_q[8];
  assign otw_s    = sync2_q[9];

  // Registers
  logic [31:0] oc_cfg_q, lim_cfg_q, retry_cfg_q;
  logic [mdfr_pkg::ST_W-1:0] st_q, st_d;
  logic clr_q;

  logic [1:0] oc_mode, oc_deg, cmp_deg, adc_deg;
  logic [3:0] cmp_mode, adc_mode;
  logic       thermal_warning_report_en;
  assign oc_mode  = oc_cfg_q[mdfr_pkg::OC_MODE_LSB +: 2];
  assign oc_deg   = oc_cfg_q[mdfr_pkg::OC_DEG_LSB +: 2];
  assign thermal_warning_report_en  = oc_cfg_q[mdfr_pkg::THERMAL_WARNING_REPORT_EN_BIT];
  assign cmp_mode = lim_cfg_q[mdfr_pkg::CMP_MODE_LSB +: 4];
  assign cmp_deg  = lim_cfg_q[mdfr_pkg::CMP_DEG_LSB +: 2];
  assign adc_mode = lim_cfg_q[mdfr_pkg::ADC_MODE_LSB +: 4];
  assign adc_deg  = lim_cfg_q[mdfr_pkg::ADC_DEG_LSB +: 2];

  // Deglitch filters, one per FET plus buck, comparator and ADC limits
  logic [5:0] fet_oc_q;
  logic       buck_ev, cmp_ev, adc_ev;
  for (genvar i = 0; i < 6; i++) begin : g_fet
    mdfr_deg_if fd ();
    assign fd.raw = fet_oc_s[i];
    assign fd.sel = oc_deg;
    assign fet_oc_q[i] = fd.qual;
    mdfr_deglitch u_deg (.pclk(pclk), .presetn(presetn), .ce(ce), .dg(fd));
  end
  mdfr_deg_if bd ();
  assign bd.raw = buck_s;
  assign bd.sel = oc_deg;
  assign buck_ev = bd.qual;
  mdfr_deglitch u_buck (.pclk(pclk), .presetn(presetn), .ce(ce), .dg(bd));
  mdfr_deg_if cd ();
  assign cd.raw = cmp_s;
  assign cd.sel = cmp_deg;
  assign cmp_ev = cd.qual;
  mdfr_deglitch u_cmp (.pclk(pclk), .presetn(presetn), .ce(ce), .dg(cd));
  mdfr_deg_if ad ();
  assign ad.raw = adc_s;
  assign ad.sel = adc_deg;
  assign adc_ev = ad.qual;
  mdfr_deglitch u_adc (.pclk(pclk), .presetn(presetn), .ce(ce), .dg(ad));

  // APB decode; zero wait states
  logic acc, wr, rd_ok;
  assign acc   = psel & penable;
  assign wr    = acc & pwrite;
  assign rd_ok = (paddr == mdfr_pkg::ADDR_OC_CFG) | (paddr == mdfr_pkg::ADDR_LIM_CFG)
               | (paddr == mdfr_pkg::ADDR_CMD) | (paddr == mdfr_pkg::ADDR_STATUS)
               | (paddr == mdfr_pkg::ADDR_RETRY_CFG);
  logic [31:0] rd_mux;
  assign rd_mux = (paddr == mdfr_pkg::ADDR_OC_CFG)    ? oc_cfg_q :
                  (paddr == mdfr_pkg::ADDR_LIM_CFG)   ? lim_cfg_q :
                  (paddr == mdfr_pkg::ADDR_RETRY_CFG) ? retry_cfg_q :
                  (paddr == mdfr_pkg::ADDR_STATUS)    ? {18'h0, st_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_cfg_q    <= mdfr_pkg::OC_CFG_RST;
      lim_cfg_q   <= mdfr_pkg::LIM_CFG_RST;
      retry_cfg_q <= mdfr_pkg::RETRY_CFG_RST;
      clr_q       <= 1'b0;
      prdata      <= '0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end else if (ce) begin
      // Clear reads back as zero and lives for one cycle
      clr_q   <= wr & (paddr == mdfr_pkg::ADDR_CMD) & pwdata[mdfr_pkg::CLR_BIT];
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_ok;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
      if (wr && paddr == mdfr_pkg::ADDR_OC_CFG)    oc_cfg_q    <= pwdata;
      if (wr && paddr == mdfr_pkg::ADDR_LIM_CFG)   lim_cfg_q   <= pwdata;
      if (wr && paddr == mdfr_pkg::ADDR_RETRY_CFG) retry_cfg_q <= pwdata;
    end
  end

  // Ready is raised in the access cycle by the setup-cycle register above;
  // a write is taken when psel, penable and pwrite are all high; pready is not decoded.

  // Retry tick prescaler shared by both retry timers
  logic [mdfr_pkg::TICK_W-1:0] pre_q;
  logic                        tick;
  assign tick = (pre_q == mdfr_pkg::TICK_W'(RETRY_TICK_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pre_q <= '0;
    else if (ce) pre_q <= tick ? '0 : pre_q + 1'b1;
  end

  // Per-fault response decode
  logic oc_act, oc_latch, oc_retry;
  assign oc_act   = |fet_oc_q && (oc_mode != 2'h3);
  assign oc_latch = oc_mode == mdfr_pkg::OC_LATCH;
  assign oc_retry = oc_mode == mdfr_pkg::OC_RETRY;

  function automatic logic lim_ignored(input logic [3:0] m);
    lim_ignored = m[3] & m[0]; // 1xx1
  endfunction : lim_ignored
  function automatic logic [1:0] lim_bridge(input logic [3:0] m);
    case (m[1:0])
      2'h2:    lim_bridge = mdfr_pkg::BR_ALL_HS;
      2'h3:    lim_bridge = mdfr_pkg::BR_ALL_LS;
      default: lim_bridge = mdfr_pkg::BR_OFF;
    endcase
  endfunction : lim_bridge

  logic cmp_on, adc_on;
  assign cmp_on = cmp_ev & ~lim_ignored(cmp_mode);
  assign adc_on = adc_ev & ~lim_ignored(adc_mode);

  // Separate state machines for the driver faults and the limit faults
  mdfr_st_t oc_st_q, oc_st_d, lk_st_q, lk_st_d;
  logic [7:0] oc_tmr_q, lk_tmr_q;
  logic [1:0] lk_br_q;
  logic       lk_is_cmp_q;
  logic       lk_evt, lk_retry_evt;
  logic [3:0] lk_mode_new;
  // A comparator in report mode must not pick the bridge for a latching converter event
  assign lk_mode_new  = (cmp_on & ~cmp_mode[3]) ? cmp_mode : adc_mode;
  assign lk_evt       = (cmp_on & ~cmp_mode[3]) | (adc_on & ~adc_mode[3]);
  assign lk_retry_evt = lk_mode_new[2];

  always_comb begin
    oc_st_d = oc_st_q;
    case (oc_st_q)
      MDFR_RUN:  if (oc_act && oc_latch) oc_st_d = MDFR_HOLD;
                 else if (oc_act && oc_retry) oc_st_d = MDFR_WAIT;
      // Leave only once the condition is gone and software cleared
      MDFR_HOLD: if (clr_q && !(|fet_oc_q)) oc_st_d = MDFR_RUN;
      MDFR_WAIT: if (tick && oc_tmr_q == 8'h0) oc_st_d = MDFR_RUN;
      default:   oc_st_d = MDFR_RUN;
    endcase
  end

  always_comb begin
    lk_st_d = lk_st_q;
    case (lk_st_q)
      MDFR_RUN:  if (lk_evt) lk_st_d = lk_retry_evt ? MDFR_WAIT : MDFR_HOLD;
      MDFR_HOLD: if (clr_q && !cmp_ev && !adc_ev) lk_st_d = MDFR_RUN;
      MDFR_WAIT: if (tick && lk_tmr_q == 8'h0) lk_st_d = MDFR_RUN;
      default:   lk_st_d = MDFR_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_st_q     <= MDFR_RUN;
      lk_st_q     <= MDFR_RUN;
      oc_tmr_q    <= '0;
      lk_tmr_q    <= '0;
      lk_br_q     <= mdfr_pkg::BR_OFF;
      lk_is_cmp_q <= 1'b0;
    end else if (ce) begin
      oc_st_q <= oc_st_d;
      lk_st_q <= lk_st_d;
      if (oc_st_q == MDFR_RUN) oc_tmr_q <= retry_cfg_q[mdfr_pkg::RETRY_LSB +: 8];
      else if (tick && oc_tmr_q != 8'h0) oc_tmr_q <= oc_tmr_q - 1'b1;
      if (lk_st_q == MDFR_RUN) begin
        lk_tmr_q    <= retry_cfg_q[mdfr_pkg::LOCK_RETRY_TIME_LSB +: 8];
        lk_br_q     <= lim_bridge(lk_mode_new);
        lk_is_cmp_q <= cmp_on & ~cmp_mode[3];
      end else if (tick && lk_tmr_q != 8'h0) begin
        lk_tmr_q <= lk_tmr_q - 1'b1;
      end
    end
  end

  // Status flags: hardware set wins over clear
  logic oc_rel, lk_rel_auto;
  assign oc_rel      = (oc_st_q == MDFR_WAIT) && (oc_st_d == MDFR_RUN);
  assign lk_rel_auto = (lk_st_q == MDFR_WAIT) && (lk_st_d == MDFR_RUN);
  logic otw_set;
  assign otw_set = otw_s & thermal_warning_report_en;

  always_comb begin
    st_d = st_q;
    if (clr_q) begin
      if (!(|fet_oc_q)) begin
        st_d[mdfr_pkg::ST_OC] = 1'b0;
        st_d[mdfr_pkg::ST_OC_FET_LSB +: 6] = 6'h0;
        // Retry releases its own fault; latch and report give way to a clear
        if (oc_st_q != MDFR_WAIT) st_d[mdfr_pkg::ST_DRV_FAULT] = 1'b0;
      end
      if (!cmp_ev) st_d[mdfr_pkg::ST_CMP_LIM] = 1'b0;
      if (!adc_ev) st_d[mdfr_pkg::ST_ADC_LIM] = 1'b0;
      if (!otw_s) begin
        st_d[mdfr_pkg::ST_OTW] = 1'b0;
        st_d[mdfr_pkg::ST_OT]  = 1'b0;
      end
      st_d[mdfr_pkg::ST_BUCK_OC] = 1'b0;
    end
    if (oc_rel) st_d[mdfr_pkg::ST_DRV_FAULT] = 1'b0;
    if (lk_rel_auto) begin
      if (lk_is_cmp_q) st_d[mdfr_pkg::ST_CMP_LIM] = 1'b0;
      else st_d[mdfr_pkg::ST_ADC_LIM] = 1'b0;
    end
    if (!st_d[mdfr_pkg::ST_CMP_LIM] && !st_d[mdfr_pkg::ST_ADC_LIM])
      st_d[mdfr_pkg::ST_CTL_FAULT] = 1'b0;
    if (oc_act && (oc_latch || oc_retry || oc_mode == mdfr_pkg::OC_REPORT)) begin
      st_d[mdfr_pkg::ST_DRV_FAULT] = 1'b1;
      st_d[mdfr_pkg::ST_OC] = 1'b1;
      st_d[mdfr_pkg::ST_OC_FET_LSB +: 6] = st_d[mdfr_pkg::ST_OC_FET_LSB +: 6] | fet_oc_q;
    end
    if (cmp_on) begin
      st_d[mdfr_pkg::ST_CMP_LIM]   = 1'b1;
      st_d[mdfr_pkg::ST_CTL_FAULT] = 1'b1;
    end
    if (adc_on) begin
      st_d[mdfr_pkg::ST_ADC_LIM]   = 1'b1;
      st_d[mdfr_pkg::ST_CTL_FAULT] = 1'b1;
    end
    if (otw_set) begin
      st_d[mdfr_pkg::ST_OTW] = 1'b1;
      st_d[mdfr_pkg::ST_OT]  = 1'b1;
    end
    if (buck_ev) st_d[mdfr_pkg::ST_BUCK_OC] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_q <= '0;
    else if (ce) st_q <= st_d;
  end

  // Outputs, all registered; a warning never touches the bridge
  logic [1:0] br_d;
  logic       flt_d;
  assign br_d = (oc_st_d != MDFR_RUN) ? mdfr_pkg::BR_OFF :
                (lk_st_d != MDFR_RUN) ? ((lk_st_q == MDFR_RUN) ? lim_bridge(lk_mode_new)
                                                               : lk_br_q) :
                mdfr_pkg::BR_NORMAL;
  assign flt_d = (oc_st_d != MDFR_RUN) | (lk_st_d != MDFR_RUN)
               | st_d[mdfr_pkg::ST_OTW] | st_d[mdfr_pkg::ST_CTL_FAULT]
               | (st_d[mdfr_pkg::ST_OC] & (oc_mode == mdfr_pkg::OC_REPORT));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_out_n  <= 1'b1;
      bridge_state <= mdfr_pkg::BR_OFF;
      buck_hiz     <= 1'b0;
      reset_req    <= 1'b0;
    end else if (ce) begin
      fault_out_n  <= ~flt_d;
      bridge_state <= br_d;
      // Buck trip: switches Hi-Z and requests a reset; both follow the qualified event and drop with it
      buck_hiz     <= buck_ev;
      reset_req    <= buck_ev;
    end
  end

  a_oc_latch_off: assert property (@(posedge pclk) disable iff (!presetn)
    ce && oc_st_q == MDFR_RUN && oc_act && oc_latch |=> bridge_state == mdfr_pkg::BR_OFF
      && !fault_out_n) else $error("latched overcurrent did not shut off");
  a_oc_hold_stay: assert property (@(posedge pclk) disable iff (!presetn)
    oc_st_q == MDFR_HOLD && !clr_q |=> oc_st_q == MDFR_HOLD)
    else $error("latched overcurrent released without clear");
  // A clear in the release cycle may legally drop the flag, so it is left out
  a_oc_retry_rel: assert property (@(posedge pclk) disable iff (!presetn)
    ce && oc_rel && !oc_act && !clr_q && st_q[mdfr_pkg::ST_OC]
      |=> !st_q[mdfr_pkg::ST_DRV_FAULT] && st_q[mdfr_pkg::ST_OC])
    else $error("retry release flags wrong");
  a_clr_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    ce && clr_q |=> !clr_q) else $error("clear lasted more than one cycle");
  a_otw_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !thermal_warning_report_en && !st_q[mdfr_pkg::ST_OTW] |=> !st_q[mdfr_pkg::ST_OTW])
    else $error("warning reported while disabled");
  a_otw_no_act: assert property (@(posedge pclk) disable iff (!presetn)
    ce && oc_st_q == MDFR_RUN && lk_st_q == MDFR_RUN && oc_st_d == MDFR_RUN
      && lk_st_d == MDFR_RUN |=> bridge_state == mdfr_pkg::BR_NORMAL)
    else $error("bridge disturbed without fault");
  a_lim_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !adc_ev && lim_ignored(cmp_mode) && lk_st_q == MDFR_RUN |=> lk_st_q == MDFR_RUN)
    else $error("ignored comparator mode acted");
  a_lk_hs_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ce && oc_st_q == MDFR_RUN && !oc_act && lk_st_q == MDFR_RUN && lk_evt
      && lk_mode_new[1:0] == 2'h2 |=> bridge_state == mdfr_pkg::BR_ALL_HS)
    else $error("limit high-side drive wrong");
  a_buck_hiz: assert property (@(posedge pclk) disable iff (!presetn)
    ce && buck_ev |=> buck_hiz && reset_req) else $error("buck trip not acted");
  c_oc_latch: cover property (@(posedge pclk) oc_st_q == MDFR_HOLD ##1 oc_st_q == MDFR_RUN);
  c_oc_retry: cover property (@(posedge pclk) oc_rel);
  c_lk_retry: cover property (@(posedge pclk) lk_rel_auto);
  c_otw:      cover property (@(posedge pclk) otw_set && !fault_out_n);
endmodule : mdfr_core
`default_nettype wire

// [rtl/mdfr_deg_if.sv]
/*
  Interface between the fault core and a deglitch filter: raw level in,
  select of the hold time, qualified event out.
  Assumes raw levels are already synchronised to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
interface mdfr_deg_if;
  logic       raw;
  logic [1:0] sel;
  logic       qual;
  modport filt (input raw, input sel, output qual);
  modport core (output raw, output sel, input qual);
endinterface : mdfr_deg_if
`default_nettype wire

// [rtl/mdfr_deglitch.sv]
/*
  Deglitch filter: qual goes high once raw has stayed high for more
  than the selected hold time, and falls with raw.
  Assumes raw is synchronous to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module mdfr_deglitch (
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  ce,
  mdfr_deg_if.filt   dg
);
  logic [mdfr_pkg::DEG_W-1:0] cnt_q;
  logic [mdfr_pkg::DEG_W-1:0] lim;
  logic                       done;

  function automatic logic [mdfr_pkg::DEG_W-1:0] deg_cyc(input logic [1:0] s);
    case (s)
      2'h0:    deg_cyc = mdfr_pkg::DEG_W'(mdfr_pkg::DEG_CYC_0);
      2'h1:    deg_cyc = mdfr_pkg::DEG_W'(mdfr_pkg::DEG_CYC_1);
      2'h2:    deg_cyc = mdfr_pkg::DEG_W'(mdfr_pkg::DEG_CYC_2);
      default: deg_cyc = mdfr_pkg::DEG_W'(mdfr_pkg::DEG_CYC_3);
    endcase
  endfunction : deg_cyc

  assign lim  = deg_cyc(dg.sel);
  // Strictly longer than the hold time
  assign done = (cnt_q > lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (!dg.raw) cnt_q <= '0;
      else if (!done) cnt_q <= cnt_q + 1'b1;
    end
  end

  assign dg.qual = dg.raw & done;
endmodule : mdfr_deglitch
`default_nettype wire

// [rtl/mdfr_pkg.sv]
/*
  Package for the motor driver fault response block: register map,
  field positions, reset values, mode codes and timing counts.
  Assumes a 100 MHz pclk and a 32-bit APB slave.
*/
`default_nettype none
package mdfr_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_OC_CFG     = 8'h00;
  localparam logic [7:0] ADDR_LIM_CFG    = 8'h04;
  localparam logic [7:0] ADDR_CMD        = 8'h08;
  localparam logic [7:0] ADDR_STATUS     = 8'h0c;
  localparam logic [7:0] ADDR_RETRY_CFG  = 8'h10;

  // Overcurrent config fields
  localparam int OC_MODE_LSB    = 0;  // 2 bits
  localparam int OC_DEG_LSB     = 4;  // 2 bits
  localparam int THERMAL_WARNING_REPORT_EN_BIT    = 8;
  // Limit config fields
  localparam int CMP_MODE_LSB   = 0;  // 4 bits
  localparam int CMP_DEG_LSB    = 4;  // 2 bits
  localparam int ADC_MODE_LSB   = 8;  // 4 bits
  localparam int ADC_DEG_LSB    = 12; // 2 bits
  // Command fields
  localparam int CLR_BIT        = 0;
  // Retry config fields, in units of one retry tick
  localparam int RETRY_LSB      = 0;  // 8 bits
  localparam int LOCK_RETRY_TIME_LSB  = 8;  // 8 bits

  // Status bit positions
  localparam int ST_DRV_FAULT   = 0;
  localparam int ST_CTL_FAULT   = 1;
  localparam int ST_OC          = 2;
  localparam int ST_OC_FET_LSB  = 3;  // 6 bits, one per FET
  localparam int ST_CMP_LIM     = 9;
  localparam int ST_ADC_LIM     = 10;
  localparam int ST_OT          = 11;
  localparam int ST_OTW         = 12;
  localparam int ST_BUCK_OC     = 13;
  localparam int ST_W           = 14;

  // Reset values
  localparam logic [31:0] OC_CFG_RST    = 32'h0000_0000;
  localparam logic [31:0] LIM_CFG_RST   = 32'h0000_9999;
  localparam logic [31:0] RETRY_CFG_RST = 32'h0000_0a05;

  // Overcurrent mode codes
  localparam logic [1:0] OC_LATCH   = 2'h0;
  localparam logic [1:0] OC_RETRY   = 2'h1;
  localparam logic [1:0] OC_REPORT  = 2'h2;

  // Deglitch choices in ns, indexed by a 2-bit select
  localparam int DEG_NS_0 = 200;
  localparam int DEG_NS_1 = 500;
  localparam int DEG_NS_2 = 1000;
  localparam int DEG_NS_3 = 2000;
  localparam int CLK_MHZ  = 100;
  localparam int DEG_CYC_0 = (DEG_NS_0 * CLK_MHZ + 999) / 1000;
  localparam int DEG_CYC_1 = (DEG_NS_1 * CLK_MHZ + 999) / 1000;
  localparam int DEG_CYC_2 = (DEG_NS_2 * CLK_MHZ + 999) / 1000;
  localparam int DEG_CYC_3 = (DEG_NS_3 * CLK_MHZ + 999) / 1000;
  localparam int DEG_W     = 8;

  // Retry tick, in us; the count is a top parameter so a bench can shorten it
  localparam int RETRY_TICK_US  = 1000;
  localparam int RETRY_TICK_CYC = RETRY_TICK_US * CLK_MHZ;
  localparam int TICK_W         = 20;

  // Bridge drive codes
  localparam logic [1:0] BR_NORMAL = 2'h0;
  localparam logic [1:0] BR_OFF    = 2'h1;
  localparam logic [1:0] BR_ALL_HS = 2'h2;
  localparam logic [1:0] BR_ALL_LS = 2'h3;

endpackage : mdfr_pkg
`default_nettype wire

// [verification/mdfr_ctrl_model.sv]
/*
  System controller model: APB master that reads status and writes the
  clear-fault command. Assumes one pclk and the slave's registered pready.
*/
`timescale 1ns/1ns
`default_nettype none
module mdfr_ctrl_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int gap = 0;
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    repeat (gap + 1) @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines change so a stale address or data cannot pass
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
  // Issued only once the bench has removed the condition, or to probe refusal
  task automatic clear_fault();
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, mdfr_pkg::ADDR_CMD, 32'h0000_0001, rd, err);
  endtask : clear_fault
endmodule : mdfr_ctrl_model
`default_nettype wire

// [verification/motor_driver_fault_response_tb.sv]
/*
  Self-checking bench for the fault response core with a controller model.
  Assumes the retry tick is shortened to 4 cycles and 20-cycle deglitch.
*/
`timescale 1ns/1ns
`default_nettype none
module motor_driver_fault_response_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  fet_oc_raw = 6'h00;
  logic        buck_oc_raw = 1'b0, cmp_lim_raw = 1'b0, adc_lim_raw = 1'b0;
  logic        otw_raw = 1'b0, err, fault_out_n, buck_hiz, reset_req;
  logic [1:0]  bridge_state;
  logic [5:0]  fet;
  int          failures = 0;
  int          total_checks = 0;
  int          codes[$] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9};
  int          n;

  always #5 pclk = ~pclk;

  mdfr_core #(.RETRY_TICK_CYC(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fet_oc_raw(fet_oc_raw),
    .buck_oc_raw(buck_oc_raw), .cmp_lim_raw(cmp_lim_raw), .adc_lim_raw(adc_lim_raw),
    .otw_raw(otw_raw), .fault_out_n(fault_out_n), .bridge_state(bridge_state),
    .buck_hiz(buck_hiz), .reset_req(reset_req));
  mdfr_ctrl_model ctl_u (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  task automatic rd_reg(input logic [7:0] a);
    ctl_u.xfer(1'b0, a, 32'h0000_0000, rd, err);
  endtask : rd_reg
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    ctl_u.xfer(1'b1, a, d, rd, err);
  endtask : wr_reg
  function automatic logic [31:0] bit_of(input int p);
    return 32'h0000_0001 << p;
  endfunction : bit_of
  function automatic logic [1:0] exp_br(input int c);
    if (c >= 8) return mdfr_pkg::BR_NORMAL;
    case (c % 4)
      2: return mdfr_pkg::BR_ALL_HS;
      3: return mdfr_pkg::BR_ALL_LS;
      default: return mdfr_pkg::BR_OFF;
    endcase
  endfunction : exp_br

  // One limit source (0 comparator, 1 converter) under one mode code
  task automatic lim_case(input int s, input int c);
    logic [31:0] lc;
    lc = 32'(c);
    wr_reg(mdfr_pkg::ADDR_LIM_CFG, (s == 0) ? (32'h0000_0900 | lc) : (32'h0000_0009 | (lc << 8)));
    if (s == 0) cmp_lim_raw <= 1'b1;
    else adc_lim_raw <= 1'b1;
    cyc(32);
    chk(bridge_state, exp_br(c));
    if (c < 8) chk(fault_out_n, 1'b0);
    if (c == 9) chk(fault_out_n, 1'b1);
    rd_reg(mdfr_pkg::ADDR_STATUS);
    chk(rd, (c == 9) ? 32'h0 : bit_of(mdfr_pkg::ST_CTL_FAULT)
        | bit_of((s == 0) ? mdfr_pkg::ST_CMP_LIM : mdfr_pkg::ST_ADC_LIM));
    cmp_lim_raw <= 1'b0;
    adc_lim_raw <= 1'b0;
    cyc(4);
    if (c < 4 || c == 8) ctl_u.clear_fault();
    cyc((c < 4 || c >= 8) ? 4 : 80);
    chk({fault_out_n, bridge_state}, {1'b1, mdfr_pkg::BR_NORMAL});
    rd_reg(mdfr_pkg::ADDR_STATUS);
    chk(rd, 32'h0);
  endtask : lim_case

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  initial begin
    #500_000;
    failures++;
    conclude();
  end

  initial begin
    n = $urandom(32'hc9cec90d);
    cyc(2);
    presetn <= 1'b1;
    cyc(2);
    rd_reg(mdfr_pkg::ADDR_LIM_CFG);
    chk(rd, mdfr_pkg::LIM_CFG_RST);
    rd_reg(mdfr_pkg::ADDR_RETRY_CFG);
    chk(rd, mdfr_pkg::RETRY_CFG_RST);
    rd_reg(8'h14);
    chk({rd[31:1], err}, 32'h0000_0001);
    // A short spike on a random FET must not trip
    n = $urandom % 6;
    fet = 6'h01 << n;
    fet_oc_raw <= fet;
    cyc(1 + $urandom % 15);
    fet_oc_raw <= 6'h00;
    cyc(30);
    chk(fault_out_n, 1'b1);
    fet_oc_raw <= fet;
    cyc(32);
    chk({fault_out_n, bridge_state}, {1'b0, mdfr_pkg::BR_OFF});
    rd_reg(mdfr_pkg::ADDR_STATUS);
    chk(rd, bit_of(mdfr_pkg::ST_DRV_FAULT) | bit_of(mdfr_pkg::ST_OC)
        | bit_of(mdfr_pkg::ST_OC_FET_LSB + n));
    ctl_u.clear_fault();
    fet_oc_raw <= 6'h00;
    cyc(8);
    chk(fault_out_n, 1'b0);
    ctl_u.clear_fault();
    cyc(4);
    chk({fault_out_n, bridge_state}, {1'b1, mdfr_pkg::BR_NORMAL});
    rd_reg(mdfr_pkg::ADDR_CMD);
    chk(rd, 32'h0);
    // Retry mode with a slow controller
    ctl_u.gap = 3;
    wr_reg(mdfr_pkg::ADDR_OC_CFG, 32'h0000_0001);
    fet_oc_raw <= fet;
    cyc(32);
    chk({fault_out_n, bridge_state}, {1'b0, mdfr_pkg::BR_OFF});
    fet_oc_raw <= 6'h00;
    cyc(60);
    chk({fault_out_n, bridge_state}, {1'b1, mdfr_pkg::BR_NORMAL});
    rd_reg(mdfr_pkg::ADDR_STATUS);
    chk(rd, bit_of(mdfr_pkg::ST_OC) | bit_of(mdfr_pkg::ST_OC_FET_LSB + n));
    ctl_u.clear_fault();
    rd_reg(mdfr_pkg::ADDR_STATUS);
    chk(rd, 32'h0);
    ctl_u.gap = 0;
    // Report-only keeps driving and flags; disabled does nothing
    for (int m = 2; m < 4; m++) begin
      wr_reg(mdfr_pkg::ADDR_OC_CFG, 32'(m));
      fet_oc_raw <= fet;
      cyc(32);
      chk({fault_out_n, bridge_state}, {m == 3, mdfr_pkg::BR_NORMAL});
      rd_reg(mdfr_pkg::ADDR_STATUS);
      chk(rd, (m == 3) ? 32'h0 : bit_of(mdfr_pkg::ST_DRV_FAULT) | bit_of(mdfr_pkg::ST_OC)
          | bit_of(mdfr_pkg::ST_OC_FET_LSB + n));
      fet_oc_raw <= 6'h00;
      cyc(4);
      ctl_u.clear_fault();
      cyc(4);
      rd_reg(mdfr_pkg::ADDR_STATUS);
      chk({rd[31:1], fault_out_n}, 32'h0000_0001);
    end
    for (int s = 0; s < 2; s++) begin
      foreach (codes[i]) lim_case(s, codes[i]);
    end
    // Thermal warning, unreported then reported
    otw_raw <= 1'b1;
    cyc(32);
    rd_reg(mdfr_pkg::ADDR_STATUS);
    chk({rd[31:1], fault_out_n}, 32'h0000_0001);
    otw_raw <= 1'b0;
    wr_reg(mdfr_pkg::ADDR_OC_CFG, bit_of(mdfr_pkg::THERMAL_WARNING_REPORT_EN_BIT));
    otw_raw <= 1'b1;
    cyc(32);
    chk({fault_out_n, bridge_state}, {1'b0, mdfr_pkg::BR_NORMAL});
    rd_reg(mdfr_pkg::ADDR_STATUS);
    chk(rd, bit_of(mdfr_pkg::ST_OT) | bit_of(mdfr_pkg::ST_OTW));
    ctl_u.clear_fault();
    otw_raw <= 1'b0;
    cyc(8);
    chk(fault_out_n, 1'b0);
    ctl_u.clear_fault();
    cyc(4);
    chk(fault_out_n, 1'b1);
    buck_oc_raw <= 1'b1;
    cyc(32);
    chk({buck_hiz, reset_req}, 2'b11);
    // Clock enable low freezes the trip even after the raw level drops
    ce <= 1'b0;
    buck_oc_raw <= 1'b0;
    cyc(8);
    chk({buck_hiz, reset_req}, 2'b11);
    ce <= 1'b1;
    cyc(8);
    chk({buck_hiz, reset_req}, 2'b00);
    conclude();
  end
endmodule : motor_driver_fault_response_tb
`default_nettype wire
